/* core/sgss_defines.svh */
// Register offsets, reset values, codes and timing for the gain set switcher
`ifndef SGSS_DEFINES_SVH
`define SGSS_DEFINES_SVH
`define SGSS_ADR_CTRL 6'h00
`define SGSS_ADR_THRESH 6'h01
`define SGSS_ADR_TCONST 6'h02
`define SGSS_ADR_STATUS 6'h03
`define SGSS_ADR_BASE0 6'h10
`define SGSS_ADR_ALT0 6'h20
`define SGSS_NUM_PARAMS 13
`define SGSS_SRC_NONE 16'h0000
`define SGSS_SRC_INPUT 16'h0001
`define SGSS_SRC_DROOP 16'h0003
`define SGSS_RST_CTRL 16'h0000
`define SGSS_RST_THRESH 16'h0000
`define SGSS_RST_TCONST 16'h0000
`define SGSS_RST_PARAM 16'h0000
`define SGSS_IDX_INERTIA 0
`define SGSS_IDX_MODEL 1
`define SGSS_IDX_VS_FIRST 5
`define SGSS_MS_NS 1000000
`define SGSS_CLK_NS 10
`define SGSS_MS_CYCLES (`SGSS_MS_NS / `SGSS_CLK_NS)
`define SGSS_FRAC 8
`endif

/* core/sgss_pkg.sv */
// Types shared by the gain set switcher
package sgss_pkg;
	typedef logic [12:0][15:0] sgss_param_vec_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sgss_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} sgss_wb_rsp_t;
	typedef enum {SGSS_SET_BASE, SGSS_SET_ALT} sgss_set_t;
endpackage

/* core/sgss_lpf.sv */
// First-order smoothing of one parameter toward its target
`timescale 1ns/10ps
`default_nettype none
`include "sgss_defines.svh"
module sgss_lpf (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [15:0] tconst_ms,
	input wire logic [15:0] target,
	output logic [15:0] value
);
	logic [23:0] acc_q, acc_d;
	logic primed_q, primed_d;
	logic signed [24:0] diff;
	logic signed [24:0] step;
	logic [23:0] target_fx;

	assign target_fx = {target, 8'h00};
	assign diff = $signed({1'b0, target_fx}) - $signed({1'b0, acc_q});
	assign step = (tconst_ms == 16'h0000) ? diff : diff / $signed({9'h000, tconst_ms});
	assign value = acc_q[23:8];

	always_comb begin
		acc_d = acc_q;
		primed_d = 1'b1;
		if (!primed_q || tconst_ms == 16'h0000) begin
			acc_d = target_fx;
		end else if (tick) begin
			// Each millisecond closes 1/tc of the gap
			if (step == 25'h0000000) begin
				acc_d = target_fx;
			end else begin
				acc_d = 24'(acc_q + 24'(step));
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			acc_q <= 24'h000000;
			primed_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			primed_q <= primed_d;
		end
	end
endmodule
`default_nettype wire

/* core/sgss_top.sv */
// Gain set switcher with Wishbone register file
// Summary of operation
// - Vibration set follows input only while motor stopped
// - Alternate inertia ratio applied while switched
// - Position, speed, integral gains swap when switched
// - Vibration and model alternates only on input
// - Input mode swaps both vibration groups, model
// - Source 0001 follows gain switch input
// - Source 0003 uses droop, keeps base vibration
// - Millisecond time constant applies to all
// - Every switched parameter passes first-order filter
// - Droop count compared against pulse threshold
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sgss_defines.svh"
module sgss_top import sgss_pkg::*; #(
	parameter int MS_CYCLES = `SGSS_MS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sgss_wb_req_t wb_req,
	output sgss_wb_rsp_t wb_rsp,
	input wire logic gain_switch_input,
	input wire logic motor_stopped,
	input wire logic [31:0] droop_abs,
	output sgss_param_vec_t eff_params,
	output logic switched
);
	// Input pin synchroniser
	logic sw_meta_q, sw_sync_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sw_meta_q <= 1'b0;
			sw_sync_q <= 1'b0;
		end else begin
			sw_meta_q <= gain_switch_input;
			sw_sync_q <= sw_meta_q;
		end
	end

	// Millisecond tick
	logic [31:0] ms_cnt_q, ms_cnt_d;
	logic ms_tick;

	assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

	always_comb begin
		ms_cnt_d = ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ms_cnt_q <= 32'h00000000;
		end else begin
			ms_cnt_q <= ms_cnt_d;
		end
	end

	// Register file
	logic [15:0] switch_source_select_q, switch_source_select_d;
	logic [15:0] switch_threshold_level_q, switch_threshold_level_d;
	logic [15:0] switch_time_constant_q, switch_time_constant_d;
	logic [15:0] base_q [`SGSS_NUM_PARAMS];
	logic [15:0] base_d [`SGSS_NUM_PARAMS];
	logic [15:0] alt_q [`SGSS_NUM_PARAMS];
	logic [15:0] alt_d [`SGSS_NUM_PARAMS];
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [5:0] word;
	logic wr_en;
	logic trigger;
	sgss_set_t gain_set_q, gain_set_d;
	sgss_set_t vs_set_q, vs_set_d;

	assign word = wb_req.adr[7:2];
	assign wr_en = wb_req.cyc && wb_req.stb && wb_req.we && !ack_q;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = dat[15:8];
		end
		return res;
	endfunction

	always_comb begin
		switch_source_select_d = switch_source_select_q;
		switch_threshold_level_d = switch_threshold_level_q;
		switch_time_constant_d = switch_time_constant_q;
		base_d = base_q;
		alt_d = alt_q;
		ack_d = wb_req.cyc && wb_req.stb && !ack_q;
		rdat_d = 32'h00000000;
		if (wr_en) begin
			if (word == `SGSS_ADR_CTRL) begin
				switch_source_select_d = merge16(switch_source_select_q, wb_req.dat, wb_req.sel);
			end
			if (word == `SGSS_ADR_THRESH) begin
				switch_threshold_level_d = merge16(switch_threshold_level_q, wb_req.dat, wb_req.sel);
			end
			if (word == `SGSS_ADR_TCONST) begin
				switch_time_constant_d = merge16(switch_time_constant_q, wb_req.dat, wb_req.sel);
			end
			for (int i = 0; i < `SGSS_NUM_PARAMS; i++) begin
				if (word == 6'(`SGSS_ADR_BASE0 + i)) begin
					base_d[i] = merge16(base_q[i], wb_req.dat, wb_req.sel);
				end
				if (word == 6'(`SGSS_ADR_ALT0 + i)) begin
					alt_d[i] = merge16(alt_q[i], wb_req.dat, wb_req.sel);
				end
			end
		end
		if (wb_req.cyc && wb_req.stb && !wb_req.we && !ack_q) begin
			if (word == `SGSS_ADR_CTRL) begin
				rdat_d = {16'h0000, switch_source_select_q};
			end
			if (word == `SGSS_ADR_THRESH) begin
				rdat_d = {16'h0000, switch_threshold_level_q};
			end
			if (word == `SGSS_ADR_TCONST) begin
				rdat_d = {16'h0000, switch_time_constant_q};
			end
			if (word == `SGSS_ADR_STATUS) begin
				rdat_d = {28'h0000000, motor_stopped, vs_set_q == SGSS_SET_ALT,
					gain_set_q == SGSS_SET_ALT, trigger};
			end
			for (int i = 0; i < `SGSS_NUM_PARAMS; i++) begin
				if (word == 6'(`SGSS_ADR_BASE0 + i)) begin
					rdat_d = {16'h0000, base_q[i]};
				end
				if (word == 6'(`SGSS_ADR_ALT0 + i)) begin
					rdat_d = {16'h0000, alt_q[i]};
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			switch_source_select_q <= `SGSS_RST_CTRL;
			switch_threshold_level_q <= `SGSS_RST_THRESH;
			switch_time_constant_q <= `SGSS_RST_TCONST;
			for (int i = 0; i < `SGSS_NUM_PARAMS; i++) begin
				base_q[i] <= `SGSS_RST_PARAM;
				alt_q[i] <= `SGSS_RST_PARAM;
			end
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			switch_source_select_q <= switch_source_select_d;
			switch_threshold_level_q <= switch_threshold_level_d;
			switch_time_constant_q <= switch_time_constant_d;
			base_q <= base_d;
			alt_q <= alt_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	// Switching condition
	always_comb begin
		unique case (switch_source_select_q)
			`SGSS_SRC_INPUT: trigger = sw_sync_q;
			`SGSS_SRC_DROOP: trigger = droop_abs >= {16'h0000, switch_threshold_level_q};
			default: trigger = 1'b0;
		endcase
	end

	// Set selection state
	always_comb begin
		gain_set_d = trigger ? SGSS_SET_ALT : SGSS_SET_BASE;
		vs_set_d = vs_set_q;
		if (motor_stopped) begin
			vs_set_d = (trigger && switch_source_select_q == `SGSS_SRC_INPUT) ? SGSS_SET_ALT : SGSS_SET_BASE;
		end
		if (switch_source_select_q != `SGSS_SRC_INPUT) begin
			vs_set_d = SGSS_SET_BASE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gain_set_q <= SGSS_SET_BASE;
			vs_set_q <= SGSS_SET_BASE;
		end else begin
			gain_set_q <= gain_set_d;
			vs_set_q <= vs_set_d;
		end
	end

	assign switched = (gain_set_q == SGSS_SET_ALT);

	// Per-parameter target and smoothing
	genvar g;
	generate
		for (g = 0; g < `SGSS_NUM_PARAMS; g++) begin : gen_param
			logic use_alt;
			logic [15:0] target;

			if (g >= `SGSS_IDX_VS_FIRST) begin : gen_vs
				assign use_alt = (vs_set_q == SGSS_SET_ALT);
			end else if (g == `SGSS_IDX_MODEL) begin : gen_model
				assign use_alt = switched && switch_source_select_q == `SGSS_SRC_INPUT;
			end else begin : gen_gain
				assign use_alt = switched;
			end

			assign target = use_alt ? alt_q[g] : base_q[g];

			sgss_lpf u_lpf (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.tick(ms_tick),
				.tconst_ms(switch_time_constant_q),
				.target(target),
				.value(eff_params[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

/* sim/sgss_host_model.sv */
// Host controller model driving the gain switch pin
`timescale 1ns/10ps
`default_nettype none
module sgss_host_model (
	input wire logic sys_clk,
	input wire logic want_on,
	output logic gain_switch_input
);
	initial gain_switch_input = 1'b0;
	// Pin follows the wanted set one clock late
	always @(posedge sys_clk) gain_switch_input <= want_on;
endmodule
`default_nettype wire

/* sim/sgss_top_assertions.sv */
// Port-level assertions for the gain set switcher
`timescale 1ns/10ps
`default_nettype none
module sgss_top_assertions import sgss_pkg::*; #(
	parameter int MS_CYCLES = 10
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sgss_wb_req_t wb_req,
	input wire sgss_wb_rsp_t wb_rsp,
	input wire logic gain_switch_input,
	input wire logic motor_stopped,
	input wire logic [31:0] droop_abs,
	input wire sgss_param_vec_t eff_params,
	input wire logic switched
);
	logic [2:0][15:0] cfg_q;
	logic [2:0][15:0] cfg_d;
	wire logic wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_rsp.ack && wb_req.adr[7:4] == 4'h0;
	// Shadow of source, threshold and time constant
	always_comb begin
		cfg_d = cfg_q;
		if (wr && wb_req.adr[3:2] != 2'h3) begin
			for (int i = 0; i < 2; i++) begin
				if (wb_req.sel[i]) cfg_d[wb_req.adr[3:2]][8*i+:8] = wb_req.dat[8*i+:8];
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) cfg_q <= '0;
		else cfg_q <= cfg_d;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_ack_pulse:
		assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
	a_ack_answer:
		assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("no ack");
	a_dat_idle:
		assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0) else $error("dat not 0");
	a_dat_upper:
		assert property (wb_rsp.ack |-> wb_rsp.dat[31:16] == 16'h0) else $error("upper dat set");
	a_pin_follow:
		assert property (cfg_q[0] == 16'h1 && $past(cfg_q[0], 2) == 16'h1 |-> switched == $past(gain_switch_input, 3))
			else $error("pin lag");
	a_droop_level:
		assert property ($past(rst_n) && $past(cfg_q[0]) == 16'h3 |-> switched == ($past(droop_abs) >= {16'h0,
			$past(cfg_q[1])})) else $error("droop switch");
	a_no_source:
		assert property ($past(rst_n) && $past(cfg_q[0]) != 16'h1 && $past(cfg_q[0]) != 16'h3 |-> !switched)
			else $error("switched idle");
	a_filter_rate:
		assert property ($past(rst_n) && $changed(eff_params) && cfg_q[2] != 16'h0 && $stable(cfg_q[2])
			|=> $stable(eff_params)) else $error("step rate");
endmodule
bind sgss_top sgss_top_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.wb_req(wb_req), .wb_rsp(wb_rsp), .gain_switch_input(gain_switch_input), .motor_stopped(motor_stopped),
	.droop_abs(droop_abs), .eff_params(eff_params), .switched(switched));
`default_nettype wire

/* sim/sgss_top_tb_top.sv */
// Self-checking bench for the gain set switcher
`timescale 1ns/10ps
`default_nettype none
module sgss_top_tb_top import sgss_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic motor_stopped = 1'b1;
	logic want_on = 1'b0;
	logic gain_switch_input;
	logic switched;
	logic [31:0] droop_abs = 32'h0;
	logic [15:0] q;
	sgss_wb_req_t wb_req = '0;
	sgss_wb_rsp_t wb_rsp;
	sgss_param_vec_t eff_params;
	int mismatches = 0;
	int total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	sgss_top #(.MS_CYCLES(10)) u_sgss_top (.sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.gain_switch_input(gain_switch_input), .motor_stopped(motor_stopped), .droop_abs(droop_abs),
		.eff_params(eff_params), .switched(switched));
	sgss_host_model u_sgss_host_model (.sys_clk(sys_clk), .want_on(want_on), .gain_switch_input(gain_switch_input));
	function automatic logic [15:0] bv(input int i);
		return 16'h0040 + 16'(i);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		wb_req <= '{1'b1, 1'b1, we, a, 4'hF, {16'h0, d}};
		do @(posedge sys_clk); while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat[15:0];
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0);
		chk(q, e);
	endtask
	task automatic chk_set(input logic [12:0] m);
		for (int i = 0; i < 13; i++) chk(eff_params[i], m[i] ? bv(i) + 16'h0100 : bv(i));
	endtask
	task automatic wsw(input logic v);
		repeat (100) if (switched !== v) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
		chk({15'h0, switched}, {15'h0, v});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'h00, 16'h0000);
		wb(1'b1, 8'h0C, 16'hFFFF);
		rd(8'h0C, 16'h0008);
		rd(8'hFC, 16'h0000);
		for (int i = 0; i < 13; i++) begin
			wb(1'b1, 8'h40 + 8'(4 * i), bv(i));
			wb(1'b1, 8'h80 + 8'(4 * i), bv(i) + 16'h0100);
		end
		rd(8'hB0, 16'h014C);
		$display("t1 done");
		wb(1'b1, 8'h00, 16'h0001);
		want_on <= 1'b1;
		wsw(1'b1);
		chk_set(13'h1FFF);
		rd(8'h0C, 16'h000F);
		want_on <= 1'b0;
		wsw(1'b0);
		chk_set(13'h0000);
		motor_stopped <= 1'b0;
		want_on <= 1'b1;
		wsw(1'b1);
		chk_set(13'h001F);
		motor_stopped <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk_set(13'h1FFF);
		want_on <= 1'b0;
		wsw(1'b0);
		$display("t2 done");
		wb(1'b1, 8'h04, 16'h0032);
		droop_abs <= 32'h31;
		wb(1'b1, 8'h00, 16'h0003);
		want_on <= 1'b1;
		wsw(1'b0);
		droop_abs <= 32'h32;
		wsw(1'b1);
		chk_set(13'h001D);
		droop_abs <= 32'h0;
		wsw(1'b0);
		$display("t3 done");
		wb(1'b1, 8'h08, 16'h0004);
		droop_abs <= 32'h32;
		wsw(1'b1);
		repeat (12) @(posedge sys_clk);
		chk({15'h0, eff_params[3] > bv(3) && eff_params[3] < bv(3) + 16'h0100}, 16'h0001);
		repeat (2000) @(posedge sys_clk);
		chk_set(13'h001D);
		$display("t4 done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
